// *** core/tdso_pkg.sv ***
// tdso_pkg: constants and carriers of the touch debug serial out block
package tdso_pkg;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int unsigned CLK_HZ       = 200_000_000;
  localparam int unsigned BIT_HZ       = 200_000;
  localparam int unsigned HALF_BIT_CYC = CLK_HZ / (2 * BIT_HZ);
  localparam int unsigned BYTE_GAP_US  = 30;
  localparam int unsigned BYTE_GAP_CYC = BYTE_GAP_US * (CLK_HZ / 1_000_000);
  localparam int unsigned MS_CYC       = CLK_HZ / 1000;
  localparam int unsigned STRAP_S      = 5;
  localparam int unsigned STRAP_MS     = STRAP_S * 1000;
  localparam int unsigned MAX_ON_S     = 30;
  localparam int unsigned MAX_ON_MS    = MAX_ON_S * 1000;
  localparam int unsigned FRAME_GAP_MS = 2;
  localparam int unsigned BOOT_WAIT    = 3;

  // ************************************************************
  // frame layout
  // ************************************************************
  localparam logic [4:0] B_COUNT  = 5'h00;
  localparam logic [4:0] B_VER    = 5'h01;
  localparam logic [4:0] B_REF    = 5'h02;
  localparam logic [4:0] B_FLAG   = 5'h1a;
  localparam logic [4:0] B_AUX    = 5'h1b;
  localparam logic [4:0] B_STAT   = 5'h1c;
  localparam logic [4:0] B_REPEAT = 5'h1d;
  localparam int unsigned ST_CAL  = 7;
  localparam int unsigned ST_NKEY = 4;
  localparam logic [3:0] VER_MAJOR = 4'h1; // arbitrary value
  localparam logic [3:0] VER_MINOR = 4'h0; // arbitrary value

  // ************************************************************
  // register map and fields
  // ************************************************************
  localparam logic [7:0] ADDR_CTRL  = 8'h00;
  localparam logic [7:0] ADDR_STAT  = 8'h04;
  localparam logic [7:0] ADDR_FLAGS = 8'h08;
  localparam logic [7:0] ADDR_IRQ   = 8'h0c;
  localparam logic [7:0] ADDR_MASK  = 8'h10;
  localparam logic       CTRL_RST   = 1'h1;
  localparam int unsigned IRQ_FRAME = 0;
  localparam int unsigned IRQ_ENTER = 1;
  localparam int unsigned IRQ_RECAL = 2;
  localparam int unsigned KEY_CLK   = 0;
  localparam int unsigned KEY_DATA  = 1;

  // ************************************************************
  // carriers
  // ************************************************************
  typedef struct packed {
    logic [15:0] reference;
    logic [15:0] sig;
    logic [15:0] delta;
  } tdso_chan_t;

  typedef struct packed {
    logic [3:0]       touch;
    logic             calibrating;
    logic [2:0]       keys_active;
    tdso_chan_t [3:0] chan;
  } tdso_acq_t;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } tdso_req_t;

endpackage

// *** core/tdso_div.sv ***
// tdso_div: divider giving a one-cycle enable pulse every DIV clocks
`timescale 1ns/1ps
module tdso_div import tdso_pkg::*; #(
  parameter int unsigned DIV = HALF_BIT_CYC
) (
  // clock and reset
  input  wire logic mclk,
  input  wire logic rst_b,
  // control and enable out
  input  wire logic clear,
  output wire logic pulse
);
  localparam int unsigned CW = $clog2(DIV);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic          pulse;
  } tdso_div_st_t;

  tdso_div_st_t st;
  tdso_div_st_t next_st;

  if (DIV < 2) begin : g_chk
    $error("tdso_div: DIV must be at least 2");
  end

  // count, restart on clear; the clear cycle is the first of the period, so every period is DIV long
  always_comb begin
    next_st = st;
    next_st.pulse = 1'b0;
    if (clear) begin
      next_st.cnt = CW'(1);
    end else if (st.cnt == CW'(DIV - 1)) begin
      next_st.cnt = '0;
      next_st.pulse = 1'b1;
    end else begin
      next_st.cnt = CW'(st.cnt + 1'b1);
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign pulse = st.pulse;
endmodule

// *** core/tdso_shift.sv ***
// tdso_shift: one byte out, msb first, on a clock and data pair
`timescale 1ns/1ps
module tdso_shift import tdso_pkg::*; #(
  parameter bit SAMPLE_RISE = 1'b1
) (
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       rst_b,
  // byte request
  input  wire logic       half_en,
  input  wire logic       start,
  input  wire logic [7:0] byte_in,
  output wire logic       busy,
  output wire logic       done,
  // line levels
  output wire logic       sclk,
  output wire logic       sdata
);
  typedef struct packed {
    logic [7:0] sh;
    logic [2:0] nbit;
    logic       low;
    logic       busy;
    logic       done;
  } tdso_shift_st_t;

  tdso_shift_st_t st;
  tdso_shift_st_t next_st;

  // data moves at the launch edge, holds through the sample edge
  always_comb begin
    next_st = st;
    next_st.done = 1'b0;
    if (!st.busy) begin
      if (start) begin
        next_st.busy = 1'b1;
        next_st.sh = byte_in;
        next_st.nbit = 3'h7;
        next_st.low = 1'b1;
      end
    end else if (half_en) begin
      if (st.low) begin
        next_st.low = 1'b0;
      end else if (st.nbit == 3'h0) begin
        next_st.busy = 1'b0;
        next_st.done = 1'b1;
      end else begin
        next_st.sh = {st.sh[6:0], 1'b0};
        next_st.nbit = 3'(st.nbit - 3'h1);
        next_st.low = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign busy = st.busy;
  assign done = st.done;
  assign sclk = st.low ^ SAMPLE_RISE;
  assign sdata = st.sh[7];
endmodule

// *** core/tdso_top.sv ***
// tdso_top: debug telemetry transmitter of a four-key touch sensor
// What this block does
// - a shorted sample_cap_three at power-up enters debug mode; release expected within 5 s
// - short held past 5 s still enters debug; key 3 reads touched ~30 s, then recal
// - debug clock and data float when idle, push-pull while a frame is sent
// - bits go out at about 200 kHz, msb of each byte first
// - frame is 30 bytes in fixed order ending with flags, status, counter
// - first byte is a 0..255 frame counter, byte 29 repeats it
// - version byte holds major revision high nibble, minor low nibble
// - references and signals bytes 2..17, deltas 18..25, low byte first
// - status bit 7 set while calibrating
// - status bits 4..6 carry the active key count
// - status bits 0..3 carry the touch state of keys 0..3
// - bytes in a frame are spaced by an idle clock interval of about 30 us
// - a frame takes about 2 ms; lines float between frames
// - otherwise the four key lines are active-low open drain
//
// Decided for this implementation: the plain strobed port and the register addresses.
`timescale 1ns/1ps
module tdso_top import tdso_pkg::*; #(
  parameter bit          SAMPLE_RISE = 1'b1,
  parameter int unsigned HALF_CYC    = HALF_BIT_CYC,
  parameter int unsigned GAP_CYC     = BYTE_GAP_CYC,
  parameter int unsigned TICK_CYC    = MS_CYC,
  parameter int unsigned WINDOW_MS   = STRAP_MS,
  parameter int unsigned ON_MS       = MAX_ON_MS,
  parameter int unsigned FGAP_MS     = FRAME_GAP_MS
) (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_b,
  // strap pin and acquisition results
  input  wire logic        sample_cap_three_short,
  input  wire tdso_acq_t   acq,
  // register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output wire logic [31:0] reg_rdata,
  // key lines, bit 0 key0_line_debug_clock, bit 1 key1_line_debug_data
  output wire logic [3:0]  key_line_o,
  output wire logic [3:0]  key_line_oe,
  // system
  output wire logic        recal_req,
  output wire logic        irq
);
  // ************************************************************
  // parameter checks
  // ************************************************************
  if (HALF_CYC < 2 || TICK_CYC < 2) begin : g_chk_div
    $error("tdso_top: dividers need at least 2 cycles");
  end
  if (GAP_CYC < 1 || GAP_CYC > 65535) begin : g_chk_gap
    $error("tdso_top: byte gap out of range");
  end
  if (WINDOW_MS < 1 || WINDOW_MS > 65535 || ON_MS < 1 || ON_MS > 65535) begin : g_chk_ms
    $error("tdso_top: ms counts out of range");
  end
  if (FGAP_MS < 1 || FGAP_MS > 255) begin : g_chk_fgap
    $error("tdso_top: frame gap out of range");
  end

  // ************************************************************
  // state
  // ************************************************************
  typedef enum logic [1:0] {M_BOOT, M_WINDOW, M_ON, M_OFF} tdso_mode_t;
  typedef enum logic [1:0] {T_IDLE, T_SHIFT, T_GAP, T_FGAP} tdso_tx_t;

  typedef struct packed {
    logic             sync1;
    logic             sync2;
    logic [1:0]       boot;
    tdso_mode_t       mode;
    logic [15:0]      ms_cnt;
    logic             ch3_bad;
    logic             recal;
    tdso_tx_t         tx;
    logic [4:0]       idx;
    logic [15:0]      gap_cnt;
    logic [7:0]       fg_cnt;
    logic [7:0]       frame_no;
    tdso_chan_t [3:0] snap_chan;
    logic [7:0]       snap_stat;
    logic [15:0]      snap_flags;
    logic             start;
    logic [7:0]       byte_out;
    logic [3:0]       key_o;
    logic [3:0]       key_oe;
    logic             tx_en;
    logic [15:0]      flags;
    logic [2:0]       irq_stat;
    logic [2:0]       irq_mask;
    logic [31:0]      rdata;
    logic             irq;
  } tdso_st_t;

  tdso_st_t  st;
  tdso_st_t  next_st;
  tdso_req_t req;
  logic      ms_tick;
  logic      half_en;
  logic      sh_busy;
  logic      sh_done;
  logic      sh_clk;
  logic      sh_data;

  assign req = '{wr: reg_wr, rd: reg_rd, addr: reg_addr, wdata: reg_wdata};

  // ************************************************************
  // dividers and shifter
  // ************************************************************
  tdso_div #(.DIV(TICK_CYC)) u_ms (
    .mclk  (mclk),
    .rst_b (rst_b),
    .clear (1'b0),
    .pulse (ms_tick)
  );

  tdso_div #(.DIV(HALF_CYC)) u_bit (
    .mclk  (mclk),
    .rst_b (rst_b),
    .clear (st.start),
    .pulse (half_en)
  );

  tdso_shift #(.SAMPLE_RISE(SAMPLE_RISE)) u_shift (
    .mclk    (mclk),
    .rst_b   (rst_b),
    .half_en (half_en),
    .start   (st.start),
    .byte_in (st.byte_out),
    .busy    (sh_busy),
    .done    (sh_done),
    .sclk    (sh_clk),
    .sdata   (sh_data)
  );

  // ************************************************************
  // frame byte selection
  // ************************************************************
  // picks byte idx of the frame from the frame snapshot
  function automatic logic [7:0] frame_byte(input logic [4:0] idx, input tdso_st_t s);
    logic [4:0]  k;
    tdso_chan_t  c;
    logic [15:0] w;
    k = 5'(idx - B_REF);
    c = s.snap_chan[k[2:1]];
    case (k[4:3])
      2'h0: w = c.reference;
      2'h1: w = c.sig;
      default: w = c.delta;
    endcase
    case (idx)
      B_COUNT, B_REPEAT: frame_byte = s.frame_no;
      B_VER: frame_byte = {VER_MAJOR, VER_MINOR};
      B_FLAG: frame_byte = s.snap_flags[7:0];
      B_AUX: frame_byte = s.snap_flags[15:8];
      B_STAT: frame_byte = s.snap_stat;
      default: frame_byte = k[0] ? w[15:8] : w[7:0];
    endcase
  endfunction

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    logic [2:0] ev;
    logic [3:0] touch_eff;
    logic       in_frame;
    logic       dbg;
    ev = 3'h0;
    touch_eff = 4'h0;
    in_frame = 1'b0;
    dbg = 1'b0;
    next_st = st;
    next_st.start = 1'b0;
    next_st.recal = 1'b0;
    next_st.rdata = 32'h0;

    // strap pin through two flops
    next_st.sync1 = sample_cap_three_short;
    next_st.sync2 = st.sync1;

    // strap capture and short window
    case (st.mode)
      M_BOOT: begin
        if (st.boot == 2'(BOOT_WAIT)) begin
          next_st.ms_cnt = 16'h0;
          if (st.sync2) begin
            next_st.mode = M_WINDOW;
            ev[IRQ_ENTER] = 1'b1;
          end else begin
            next_st.mode = M_OFF;
          end
        end else begin
          next_st.boot = 2'(st.boot + 2'h1);
        end
      end
      M_WINDOW: begin
        if (!st.sync2) begin
          next_st.mode = M_ON;
        end else if (ms_tick) begin
          if (st.ms_cnt == 16'(WINDOW_MS - 1)) begin
            next_st.mode = M_ON;
            next_st.ch3_bad = 1'b1;
            next_st.ms_cnt = 16'h0;
          end else begin
            next_st.ms_cnt = 16'(st.ms_cnt + 16'h1);
          end
        end
      end
      default: begin
        if (st.ch3_bad && ms_tick) begin
          if (st.ms_cnt == 16'(ON_MS - 1)) begin
            next_st.ch3_bad = 1'b0;
            next_st.recal = 1'b1;
            ev[IRQ_RECAL] = 1'b1;
          end else begin
            next_st.ms_cnt = 16'(st.ms_cnt + 16'h1);
          end
        end
      end
    endcase

    // key 3 reads touched from the window timeout until the recal, whether the short is still held or not
    touch_eff = acq.touch | {st.ch3_bad, 3'h0};

    // frame sequencer
    case (st.tx)
      T_IDLE: begin
        if (st.mode == M_ON && st.tx_en) begin
          next_st.snap_chan = acq.chan;
          next_st.snap_flags = st.flags;
          next_st.snap_stat[ST_CAL] = acq.calibrating;
          next_st.snap_stat[ST_NKEY +: 3] = acq.keys_active;
          next_st.snap_stat[3:0] = touch_eff;
          next_st.idx = B_COUNT;
          next_st.byte_out = st.frame_no;
          next_st.start = 1'b1;
          next_st.tx = T_SHIFT;
        end
      end
      T_SHIFT: begin
        if (sh_done) begin
          next_st.gap_cnt = 16'h0;
          if (st.idx == B_REPEAT) begin
            next_st.frame_no = 8'(st.frame_no + 8'h1);
            next_st.fg_cnt = 8'h0;
            next_st.tx = T_FGAP;
            ev[IRQ_FRAME] = 1'b1;
          end else begin
            next_st.tx = T_GAP;
          end
        end
      end
      T_GAP: begin
        if (st.gap_cnt == 16'(GAP_CYC - 1)) begin
          next_st.idx = 5'(st.idx + 5'h1);
          next_st.byte_out = frame_byte(5'(st.idx + 5'h1), st);
          next_st.start = 1'b1;
          next_st.tx = T_SHIFT;
        end else begin
          next_st.gap_cnt = 16'(st.gap_cnt + 16'h1);
        end
      end
      default: begin
        if (ms_tick) begin
          if (st.fg_cnt == 8'(FGAP_MS - 1)) begin
            next_st.tx = T_IDLE;
          end else begin
            next_st.fg_cnt = 8'(st.fg_cnt + 8'h1);
          end
        end
      end
    endcase

    // pins: debug pair push-pull within a frame, floating between frames in debug mode, open drain otherwise
    in_frame = (st.tx == T_SHIFT) || (st.tx == T_GAP);
    dbg = (st.mode == M_WINDOW) || (st.mode == M_ON);
    next_st.key_o = 4'h0;
    next_st.key_oe = touch_eff;
    if (dbg) begin
      next_st.key_o[KEY_CLK] = in_frame ? sh_clk : 1'b0;
      next_st.key_o[KEY_DATA] = in_frame ? sh_data : 1'b0;
      next_st.key_oe[KEY_CLK] = in_frame;
      next_st.key_oe[KEY_DATA] = in_frame;
    end

    // register writes
    if (req.wr) begin
      case (req.addr)
        ADDR_CTRL: next_st.tx_en = req.wdata[0];
        ADDR_FLAGS: next_st.flags = req.wdata[15:0];
        ADDR_IRQ: next_st.irq_stat = st.irq_stat & ~req.wdata[2:0];
        ADDR_MASK: next_st.irq_mask = req.wdata[2:0];
        default: next_st.irq_mask = st.irq_mask;
      endcase
    end

    // register reads, data in the next cycle only
    if (req.rd) begin
      case (req.addr)
        ADDR_CTRL: next_st.rdata = {31'h0, st.tx_en};
        ADDR_STAT: next_st.rdata = {16'h0, st.frame_no, 4'h0, st.mode == M_WINDOW,
                                    in_frame, st.ch3_bad, dbg};
        ADDR_FLAGS: next_st.rdata = {16'h0, st.flags};
        ADDR_IRQ: next_st.rdata = {29'h0, st.irq_stat};
        ADDR_MASK: next_st.rdata = {29'h0, st.irq_mask};
        default: next_st.rdata = 32'h0;
      endcase
    end

    // sticky events, a set beats a clear in the same cycle
    next_st.irq_stat = next_st.irq_stat | ev;
    next_st.irq = |(next_st.irq_stat & next_st.irq_mask);
  end

  // ************************************************************
  // state register
  // ************************************************************
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      st <= '0;
      st.mode <= M_BOOT;
      st.tx <= T_IDLE;
      st.tx_en <= CTRL_RST;
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from flops
  assign reg_rdata = st.rdata;
  assign key_line_o = st.key_o;
  assign key_line_oe = st.key_oe;
  assign recal_req = st.recal;
  assign irq = st.irq;
endmodule

// *** sim/tdso_checker.sv ***
// tdso_checker: timing checks on the debug link and key lines
`timescale 1ns/1ps
module tdso_checker #(
  parameter int unsigned HALF_CYC = 4,
  parameter int unsigned GAP_CYC  = 10
) (
  // clock and reset
  input wire logic       mclk,
  input wire logic       rst_b,
  // watched outputs
  input wire logic [3:0] key_line_o,
  input wire logic [3:0] key_line_oe,
  input wire logic       recal_req
);
  // ************************************************************
  // debug clock stretch counters
  // ************************************************************
  logic [15:0] lo_n;
  logic [15:0] hi_n;
  logic [8:0]  rise_n;
  logic        clk_q;

  // low and high run lengths, rising edges per frame
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      lo_n   <= 16'h0;
      hi_n   <= 16'h0;
      rise_n <= 9'h0;
      clk_q  <= 1'b1;
    end else begin
      lo_n   <= (key_line_o[0] || !key_line_oe[0]) ? 16'h0 : lo_n + 16'h1;
      hi_n   <= (!key_line_o[0] || !key_line_oe[0]) ? 16'h0 : hi_n + 16'h1;
      rise_n <= !key_line_oe[0] ? 9'h0 : rise_n + {8'h0, key_line_o[0] & !clk_q};
      clk_q  <= key_line_oe[0] ? key_line_o[0] : 1'b1; // wire level, pulled up while floating
    end
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);

  // the clock enters the frame at its idle high level together with the enable
  AST_HALF_LOW: assert property ($rose(key_line_o[0]) && key_line_oe[0] && $past(key_line_oe[0])
      |-> lo_n == HALF_CYC)
    else $error("debug clock low half has wrong length");
  // high half checked over four cycles, the bench half length
  AST_DATA_HOLD: assert property ($rose(key_line_o[0]) && key_line_oe[1] && $past(key_line_oe[0])
      |-> $stable(key_line_o[1]) [*4])
    else $error("debug data moved while clock high");
  AST_PUSH_PULL: assert property (key_line_oe[1:0] != 2'h0 && key_line_o[0] |-> key_line_oe[1:0] == 2'h3)
    else $error("debug lines not driven together");
  AST_OPEN_DRAIN: assert property (key_line_oe[3:2] != 2'h0 |-> key_line_o[3:2] == 2'h0)
    else $error("key line driven high");
  // gap stretch: high half, done handshake, the idle count, then the start handshake
  AST_BYTE_GAP: assert property ($fell(key_line_o[0]) && key_line_oe[0] && rise_n != 9'h0 |->
      hi_n == HALF_CYC || (hi_n >= HALF_CYC + GAP_CYC && hi_n <= HALF_CYC + GAP_CYC + 2))
    else $error("debug clock high stretch wrong");
  AST_FRAME_FLOAT: assert property ($fell(key_line_oe[0]) && $past(key_line_o[0]) |-> (!key_line_oe[0]) [*8])
    else $error("debug lines did not float between frames");
  AST_FRAME_BITS: assert property ($fell(key_line_oe[0]) && $past(key_line_o[0]) |-> rise_n == 9'd240)
    else $error("frame did not carry 240 bits");
  AST_RECAL_PULSE: assert property (recal_req |=> !recal_req)
    else $error("recal request longer than one cycle");
endmodule

bind tdso_top tdso_checker #(.HALF_CYC(HALF_CYC), .GAP_CYC(GAP_CYC)) chk_u (
  .mclk(mclk), .rst_b(rst_b), .key_line_o(key_line_o), .key_line_oe(key_line_oe), .recal_req(recal_req));

// *** sim/tdso_monitor.sv ***
// tdso_monitor: external monitor capturing the debug clock and data lines
`timescale 1ns/1ps
module tdso_monitor #(
  parameter bit SAMPLE_RISE = 1'b1
) (
  // clock
  input  wire logic  mclk,
  // sensed lines
  input  wire logic  clk_w,
  input  wire logic  dat_w,
  input  wire logic  en_w,
  // captured frame
  output logic [7:0] fb [0:29],
  output int         nbits,
  output int         frames
);
  // ************************************************************
  // capture
  // ************************************************************
  logic       clk_q = 1'b1;
  logic       en_q  = 1'b0;
  logic [7:0] sh    = 8'h0;

  // sample data on the edge opposite the change edge
  always @(posedge mclk) begin
    clk_q <= clk_w;
    en_q  <= en_w;
    if (en_w && !en_q) begin
      nbits <= 0;
    end else if (en_w && clk_w != clk_q && clk_w == SAMPLE_RISE) begin
      sh = {sh[6:0], dat_w};
      nbits <= nbits + 1;
      if (nbits < 240 && nbits % 8 == 7) begin
        fb[nbits / 8] <= sh;
      end
    end
    if (en_q && !en_w) begin
      frames <= frames + 1;
    end
  end
endmodule

// *** sim/tdso_bench.sv ***
// tdso_bench: self-checking bench of the touch debug serial out block
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin n_fail++; \
  $display("[FAIL] %s exp %h got %h", nm, ex, got); end end
module tdso_bench import tdso_pkg::*;;
  // ************************************************************
  // signals and instances
  // ************************************************************
  logic        mclk      = 1'b0;
  logic        rst_b     = 1'b0;
  logic        short_pin = 1'b1;
  logic        reg_wr    = 1'b0;
  logic        reg_rd    = 1'b0;
  logic [7:0]  reg_addr  = 8'h0;
  logic [31:0] reg_wdata = 32'h0;
  tdso_acq_t   acq;
  logic [31:0] reg_rdata;
  logic [31:0] rd_v;
  logic [3:0]  kl_o;
  logic [3:0]  kl_oe;
  logic        recal_req;
  logic        irq;
  logic        clk_w;
  logic        dat_w;
  logic [7:0]  fb [0:29];
  int          nbits;
  int          frames;
  int          n_fail       = 0;
  int          total_checks = 0;
  int          cyc          = 0;

  tdso_top #(.HALF_CYC(4), .GAP_CYC(10), .TICK_CYC(20), .WINDOW_MS(3), .ON_MS(150)) dut_u (
    .mclk(mclk), .rst_b(rst_b), .sample_cap_three_short(short_pin), .acq(acq), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .key_line_o(kl_o), .key_line_oe(kl_oe), .recal_req(recal_req), .irq(irq));

  // wire levels with pull-ups
  assign clk_w = kl_oe[KEY_CLK] ? kl_o[KEY_CLK] : 1'b1;
  assign dat_w = kl_oe[KEY_DATA] ? kl_o[KEY_DATA] : 1'b1;

  tdso_monitor mon_u (.mclk(mclk), .clk_w(clk_w), .dat_w(dat_w), .en_w(kl_oe[KEY_CLK]), .fb(fb),
    .nbits(nbits), .frames(frames));

  // clock and hang guard
  always #2.5 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_fail++;
      end_of_test();
    end
  end

  // ************************************************************
  // helpers
  // ************************************************************
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    rd_v = reg_rdata;
  endtask

  function automatic logic [7:0] exp_byte(input int i, input logic [7:0] ctr, input logic [15:0] fl,
                                          input logic k3);
    logic [15:0] w;
    w = (i < 10) ? acq.chan[((i + 6) / 2) % 4].reference :
        (i < 18) ? acq.chan[((i + 6) / 2) % 4].sig : acq.chan[((i + 6) / 2) % 4].delta;
    case (i)
      0, 29: return ctr;
      1: return {VER_MAJOR, VER_MINOR};
      26: return fl[7:0];
      27: return fl[15:8];
      28: return {acq.calibrating, acq.keys_active, acq.touch | {k3, 3'h0}};
      default: return i[0] ? w[15:8] : w[7:0];
    endcase
  endfunction

  task automatic wait_frame();
    int f0;
    f0 = frames;
    for (int i = 0; i < 6000 && frames == f0; i++) @(posedge mclk);
    `CHK("frame seen", 1'b1, frames != f0)
    repeat (2) @(posedge mclk);
  endtask

  task automatic chk_frame(input logic [7:0] ctr, input logic [15:0] fl, input logic k3);
    `CHK("bit count", 240, nbits)
    for (int i = 0; i < 30; i++) `CHK("frame byte", exp_byte(i, ctr, fl, k3), fb[i])
    `CHK("counter repeat", fb[0], fb[29])
  endtask

  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_entry();
    rd(ADDR_CTRL);
    `CHK("ctrl reset", 32'h1, rd_v)
    rd(ADDR_MASK);
    `CHK("mask reset", 32'h0, rd_v)
    rd(8'h14);
    `CHK("unmapped read", 32'h0, rd_v)
    wr(ADDR_FLAGS, 32'h5aa5);
    wr(ADDR_MASK, 32'h1);
    repeat (20) @(posedge mclk);
    `CHK("float in window", 2'h0, kl_oe[1:0])
    short_pin <= 1'b0;
    repeat (10) @(posedge mclk);
    rd(ADDR_STAT);
    `CHK("debug mode", 1'b1, rd_v[0])
    `CHK("entry masked", 1'b0, irq)
    wait_frame();
    chk_frame(8'h0, 16'h5aa5, 1'b0);
    `CHK("frame irq", 1'b1, irq)
    rd(ADDR_IRQ);
    `CHK("irq status", 32'h3, rd_v)
    wr(ADDR_IRQ, 32'h3);
    rd(ADDR_IRQ);
    `CHK("irq cleared", 32'h0, rd_v)
    `CHK("irq low", 1'b0, irq)
  endtask

  task automatic t_second();
    acq.calibrating <= 1'b1;
    acq.keys_active <= 3'h3;
    acq.touch       <= 4'h5;
    wait_frame();
    chk_frame(8'h1, 16'h5aa5, 1'b0);
  endtask

  task automatic t_hold();
    @(posedge mclk);
    rst_b     <= 1'b0;
    short_pin <= 1'b1;
    acq.touch <= 4'h0;
    repeat (4) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (90) @(posedge mclk);
    rd(ADDR_STAT);
    `CHK("key3 unusable", 2'h3, rd_v[1:0])
    `CHK("key3 line", 1'b1, kl_oe[3])
    short_pin <= 1'b0;
    wait_frame();
    chk_frame(8'h0, 16'h0, 1'b1);
    for (int i = 0; i < 4000 && recal_req !== 1'b1; i++) begin
      @(posedge mclk);
      #1;
    end
    `CHK("recal pulse", 1'b1, recal_req)
    rd(ADDR_STAT);
    `CHK("key3 usable", 1'b0, rd_v[1])
  endtask

  task automatic t_normal();
    int f0;
    @(posedge mclk);
    rst_b     <= 1'b0;
    short_pin <= 1'b0;
    acq.touch <= 4'ha;
    repeat (4) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (10) @(posedge mclk);
    f0 = frames;
    repeat (300) @(posedge mclk);
    #1;
    `CHK("key enables", 4'ha, kl_oe)
    `CHK("key levels", 4'h0, kl_o)
    `CHK("no frames", f0, frames)
  endtask

  task automatic end_of_test();
    $display("checks %0d, failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    acq = '0;
    acq.keys_active = 3'h4;
    for (int c = 0; c < 4; c++) begin
      acq.chan[c].reference = 16'h1201 + 16'(c);
      acq.chan[c].sig       = 16'h3402 + 16'(c * 257);
      acq.chan[c].delta     = 16'hff80 - 16'(c);
    end
    repeat (12) @(posedge mclk);
    rst_b <= 1'b1;
    t_entry();
    t_second();
    t_hold();
    t_normal();
    end_of_test();
  end
endmodule
